//--- gpio_ports.sv
/*
 * Two open-drain GPIO ports behind a relocatable I/O base, with an AHB-Lite
 * register slave. Assumes the pins carry external pull-ups (modelled outside),
 * a single clock CLK_I, and a strap level that is stable around reset release.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_ports #(
  parameter int PORT_W = gpio_pkg::PORT_W
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // configuration strap
  input wire logic PORT_ENABLE_STRAP_I,
  // port 1 pins, open drain
  input wire logic [PORT_W-1:0] GPIO1_I,
  output logic [PORT_W-1:0] GPIO1_O,
  output logic [PORT_W-1:0] GPIO1_OE_O,
  // port 2 pins, open drain
  input wire logic [PORT_W-1:0] GPIO2_I,
  output logic [PORT_W-1:0] GPIO2_O,
  output logic [PORT_W-1:0] GPIO2_OE_O
);

  // address map, as byte addresses on the bus:
  //   the 16-bit I/O space is folded onto words, I/O address n at byte 4*n,
  //   so the port window needs haddr[31:18] and haddr[1:0] at zero
  //   port 1 answers at I/O base + 0 and port 2 at I/O base + 1
  //   the base and status words sit above the I/O window, so no base that
  //   software can choose ever puts a port on top of them
  // timing:
  //   zero wait states; read data is formed at the address edge and stands
  //   for the one data-phase cycle
  //   a write lands at its data-phase edge, so a pipelined read issued at
  //   that same edge still sees the old value
  //   pin levels reach a read two clocks late, through the synchroniser
  //   the strap is taken at the third edge after reset release

  // configuration and enable state
  logic [7:0] base_cfg_r;
  logic ports_en_r;
  logic strap_taken_r;
  logic [1:0] settle_r;

  // synchronised pin and strap levels
  logic strap_sync;
  logic [PORT_W-1:0] pins1_sync;
  logic [PORT_W-1:0] pins2_sync;

  // bus pipeline
  gpio_pkg::ahb_req_s req_r;
  gpio_pkg::ahb_req_s req_nxt;
  logic [31:0] rdata_nxt;
  logic addr_phase;

  // decode one bus address against the live base and enable
  function automatic gpio_pkg::reg_sel_e decode(input logic [31:0] addr,
                                                input logic [7:0] base,
                                                input logic en);
    logic [15:0] io_addr;
    logic [15:0] io_base;
    io_addr = addr[17:2];
    io_base = {6'h00, base, 2'h0};
    decode = gpio_pkg::SEL_NONE;
    // config and status words answer even while the ports are disabled
    // base + index cannot carry out of 16 bits: the base tops out at 3fch
    if (addr == gpio_pkg::BASE_CFG_ADDR) begin
      decode = gpio_pkg::SEL_BASE;
    end else if (addr == gpio_pkg::STATUS_ADDR) begin
      decode = gpio_pkg::SEL_STATUS;
    end else if (addr[31:18] == gpio_pkg::IO_SPACE_TOP && addr[1:0] == 2'h0 && en) begin
      // whole 16-bit address must match; disabled ports stay silent
      if (io_addr == io_base + gpio_pkg::PORT1_IDX) begin
        decode = gpio_pkg::SEL_PORT1;
      end else if (io_addr == io_base + gpio_pkg::PORT2_IDX) begin
        decode = gpio_pkg::SEL_PORT2;
      end
    end
  endfunction

  // pin and strap levels come from outside the clock domain
  // strap and pins share one synchroniser; all sit idle high after reset
  gpio_sync #(
    .WIDTH(2 * PORT_W + 1),
    .RST_VAL('1)
  ) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .async_i({PORT_ENABLE_STRAP_I, GPIO2_I, GPIO1_I}),
    .sync_o({strap_sync, pins2_sync, pins1_sync})
  );

  // only whole-word single transfers are expected; hsize is not checked
  assign addr_phase = HSEL_I && HREADY_I && (HTRANS_I == gpio_pkg::HTRANS_NONSEQ
                      || HTRANS_I == 2'h3);

  // address phase decode, kept for the data phase
  always_comb begin
    req_nxt.wr = 1'b0;
    req_nxt.sel = gpio_pkg::SEL_NONE;
    if (addr_phase) begin
      req_nxt.wr = HWRITE_I;
      req_nxt.sel = decode(HADDR_I, base_cfg_r, ports_en_r);
    end
  end

  // read data formed in the address phase so it stands from a flop in the data phase
  // unmapped, misaligned and disabled reads give zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (addr_phase && !HWRITE_I) begin
      case (req_nxt.sel)
        gpio_pkg::SEL_PORT1: rdata_nxt[PORT_W-1:0] = pins1_sync;
        gpio_pkg::SEL_PORT2: rdata_nxt[PORT_W-1:0] = pins2_sync;
        gpio_pkg::SEL_BASE: rdata_nxt[7:0] = base_cfg_r;
        gpio_pkg::SEL_STATUS: begin
          rdata_nxt[gpio_pkg::STAT_EN_BIT] = ports_en_r;
          rdata_nxt[gpio_pkg::STAT_STRAP_BIT] = strap_sync;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // bus request register
  // only the data phase needs the write flag and the target
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      req_r <= '{wr: 1'b0, sel: gpio_pkg::SEL_NONE};
    end else begin
      req_r <= req_nxt;
    end
  end

  // bus answer: zero wait states, always OKAY, unmapped reads zero
  // hsize is not checked, so a narrow write still lands its low byte
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      HRDATA_O <= rdata_nxt;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  // base address configuration
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      base_cfg_r <= gpio_pkg::BASE_CFG_RST;
    end else if (req_r.wr && req_r.sel == gpio_pkg::SEL_BASE) begin
      base_cfg_r <= HWDATA_I[7:0];
    end
  end

  // strap taken once, after it has crossed the synchroniser
  // a strap that moves after reset is ignored until the next reset
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      settle_r <= 2'h0;
      strap_taken_r <= 1'b0;
      ports_en_r <= 1'b0;
    end else if (!strap_taken_r) begin
      if (settle_r == gpio_pkg::STRAP_SETTLE) begin
        strap_taken_r <= 1'b1;
        ports_en_r <= strap_sync;
      end else begin
        settle_r <= settle_r + 2'h1;
      end
    end
  end

  // output latches held as drive enables: a 0 bit drives low, a 1 releases
  // port writes while disabled never decode, so the latches keep their reset value and every pin stays released
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      GPIO1_OE_O <= ~gpio_pkg::LATCH_RST[PORT_W-1:0];
      GPIO2_OE_O <= ~gpio_pkg::LATCH_RST[PORT_W-1:0];
    end else if (req_r.wr) begin
      if (req_r.sel == gpio_pkg::SEL_PORT1) begin
        GPIO1_OE_O <= ~HWDATA_I[PORT_W-1:0];
      end
      if (req_r.sel == gpio_pkg::SEL_PORT2) begin
        GPIO2_OE_O <= ~HWDATA_I[PORT_W-1:0];
      end
    end
  end

  // open drain only ever drives low
  // kept as a flop so every output of the block leaves a register
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      GPIO1_O <= '0;
      GPIO2_O <= '0;
    end else begin
      GPIO1_O <= '0;
      GPIO2_O <= '0;
    end
  end

endmodule

`default_nettype wire

//--- gpio_pkg.sv
/*
 * Shared constants and types for the dual open-drain GPIO port block.
 * Assumes a 32-bit AHB-Lite bus, one word per register, and a 16-bit I/O space
 * folded onto word addresses (I/O address n sits at byte address 4*n).
 */
`default_nettype none

package gpio_pkg;

  // width of one port and of the I/O address
  localparam int PORT_W = 8;
  localparam int IO_ADDR_W = 16;

  // port register indices from the port base
  localparam logic [15:0] PORT1_IDX = 16'h0000;
  localparam logic [15:0] PORT2_IDX = 16'h0001;

  // configuration window, outside the folded I/O space
  localparam logic [31:0] BASE_CFG_ADDR = 32'h0004_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h0004_0004;
  localparam logic [13:0] IO_SPACE_TOP = 14'h0000;

  // field positions
  localparam int BASE_LSB = 2;
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_STRAP_BIT = 1;

  // reset values
  localparam logic [7:0] BASE_CFG_RST = 8'h1e;
  localparam logic [7:0] LATCH_RST = 8'hff;

  // cycles the strap is given to pass its synchroniser before it is taken
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum {
    SEL_NONE,
    SEL_PORT1,
    SEL_PORT2,
    SEL_BASE,
    SEL_STATUS
  } reg_sel_e;

  // address phase kept for the following data phase
  typedef struct packed {
    logic wr;
    reg_sel_e sel;
  } ahb_req_s;

endpackage

`default_nettype wire

//--- gpio_sync.sv
/*
 * Two-stage synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous to clk_i; only the second stage is read.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds the second and nothing else
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

`default_nettype wire

//--- gpio_pin_model.sv
/* pin side of one open-drain port: pull-up plus an external sink.
   assumes the design drives low only where its enable is high */
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_model #(parameter int W = 8) (
  // design drive and external sink
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] o_i,
  input wire logic [W-1:0] ext_low_i,
  // resolved level
  output logic [W-1:0] pin_o
);
  // pull-up wins only where nobody sinks the line
  assign pin_o = (oe_i & o_i) | (~oe_i & ~ext_low_i);
endmodule
`default_nettype wire

//--- gpio_ports_assertions.sv
/* port-level checker for gpio_ports.
   assumes hready is looped back and one clock domain */
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_chk #(parameter int PORT_W = 8) (
  // bus, strap, pins
  input wire logic CLK_I, RST_N_I, HSEL_I, HWRITE_I, HREADY_I, PORT_ENABLE_STRAP_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic [31:0] HADDR_I, HWDATA_I, HRDATA_O,
  input wire logic HREADYOUT_O, HRESP_O,
  input wire logic [PORT_W-1:0] GPIO1_O, GPIO1_OE_O, GPIO2_O, GPIO2_OE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // an address phase taken this edge
  logic take;
  assign take = HSEL_I && HREADY_I && HTRANS_I[1];
  property p_oe_rst; $rose(RST_N_I) |-> (GPIO1_OE_O | GPIO2_OE_O) == 0; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pin driven after reset");
  property p_od; GPIO1_O == 0 && GPIO2_O == 0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_ok; HREADYOUT_O && !HRESP_O; endproperty
  a_ok: assert property (p_ok) else $error("bus not ready or error");
  property p_wr; !$stable(GPIO1_OE_O) |-> $past(take && HWRITE_I, 2); endproperty
  a_wr: assert property (p_wr) else $error("drive changed without write");
  property p_wd; !$stable(GPIO1_OE_O) |-> GPIO1_OE_O == ~$past(HWDATA_I[PORT_W-1:0]); endproperty
  a_wd: assert property (p_wd) else $error("drive differs from written data");
  // strap only ever changes while reset is held; disabled ports ignore writes
  property p_dis;
    !PORT_ENABLE_STRAP_I |-> $stable(GPIO1_OE_O) && $stable(GPIO2_OE_O);
  endproperty
  a_dis: assert property (p_dis) else $error("disabled port changed");
  property p_mis; take && !HWRITE_I && HADDR_I[1:0] != 0 |=> HRDATA_O == 0; endproperty
  a_mis: assert property (p_mis) else $error("misaligned read answered");
  property p_hi; HRDATA_O[31:PORT_W] == 0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
endmodule
bind gpio_ports gpio_ports_chk #(.PORT_W(PORT_W)) chk_inst (
  .CLK_I(CLK_I),
  .RST_N_I(RST_N_I),
  .HSEL_I(HSEL_I),
  .HWRITE_I(HWRITE_I),
  .HREADY_I(HREADY_I),
  .PORT_ENABLE_STRAP_I(PORT_ENABLE_STRAP_I),
  .HTRANS_I(HTRANS_I),
  .HADDR_I(HADDR_I),
  .HWDATA_I(HWDATA_I),
  .HRDATA_O(HRDATA_O),
  .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O),
  .GPIO1_O(GPIO1_O),
  .GPIO1_OE_O(GPIO1_OE_O),
  .GPIO2_O(GPIO2_O),
  .GPIO2_OE_O(GPIO2_OE_O)
);
`default_nettype wire

//--- tb_top.sv
/* self-checking bench for gpio_ports: AHB-Lite master, pin models.
   assumes the checker is bound to the design */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic CLK_I, RST_N_I, HSEL_I, HWRITE_I, PORT_ENABLE_STRAP_I, HREADYOUT_O, HRESP_O;
  logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, rd;
  logic [1:0] HTRANS_I;
  logic [7:0] GPIO1_I, GPIO2_I, GPIO1_O, GPIO2_O, GPIO1_OE_O, GPIO2_OE_O, low1, low2;
  wire logic HREADY_I = HREADYOUT_O;
  wire logic [2:0] HSIZE_I = 3'h2;
  int err_count, samples_checked;
  // byte offset from 0x1e0, written value, external sink, expected read
  logic [7:0] rows [4][4] = '{'{8'h00, 8'h0f, 8'h00, 8'h0f}, '{8'h04, 8'ha5, 8'h00, 8'ha5},
    '{8'h00, 8'hff, 8'h3c, 8'hc3}, '{8'h04, 8'h00, 8'hff, 8'h00}};
  gpio_ports gpio_ports_inst (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I),
    .HSIZE_I(HSIZE_I),
    .HWDATA_I(HWDATA_I),
    .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O),
    .HRESP_O(HRESP_O),
    .PORT_ENABLE_STRAP_I(PORT_ENABLE_STRAP_I),
    .GPIO1_I(GPIO1_I),
    .GPIO1_O(GPIO1_O),
    .GPIO1_OE_O(GPIO1_OE_O),
    .GPIO2_I(GPIO2_I),
    .GPIO2_O(GPIO2_O),
    .GPIO2_OE_O(GPIO2_OE_O)
  );
  gpio_pin_model p1_inst (.oe_i(GPIO1_OE_O), .o_i(GPIO1_O), .ext_low_i(low1), .pin_o(GPIO1_I));
  gpio_pin_model p2_inst (.oe_i(GPIO2_OE_O), .o_i(GPIO2_O), .ext_low_i(low2), .pin_o(GPIO2_I));
  // clock and time-zero values
  initial begin
    {CLK_I, RST_N_I, HSEL_I, HWRITE_I, HTRANS_I, HADDR_I, HWDATA_I, low1, low2} = '0;
    PORT_ENABLE_STRAP_I = 1'b1;
    forever #50 CLK_I = ~CLK_I;
  end
  // one single transfer; waits on hready rather than assuming zero wait states
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    HSEL_I <= 1'b1;
    HADDR_I <= a;
    HWRITE_I <= w;
    HTRANS_I <= 2'h2;
    do @(posedge CLK_I); while (!HREADYOUT_O);
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    do @(posedge CLK_I); while (!HREADYOUT_O);
    rd = HRDATA_O;
  endtask
  // strap is set while reset is held; ports answer from the 4th edge after release
  task automatic do_reset(input logic strap);
    RST_N_I <= 1'b0;
    PORT_ENABLE_STRAP_I <= strap;
    repeat (10) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    do_reset(1'b1);
    `CHK(GPIO1_OE_O | GPIO2_OE_O, 8'h00)
    xfer(32'h4_0000, 1'b0, 32'h0);
    `CHK(rd, 32'h1e)
    xfer(32'h4_0004, 1'b0, 32'h0);
    `CHK(rd, 32'h3)
    xfer(32'h1e4, 1'b0, 32'h0);
    `CHK(rd, 32'hff)
    foreach (rows[i]) begin
      if (rows[i][0][2]) low2 <= rows[i][2];
      else low1 <= rows[i][2];
      xfer(32'h1e0 + rows[i][0], 1'b1, {24'h0, rows[i][1]});
      repeat (4) @(posedge CLK_I);
      xfer(32'h1e0 + rows[i][0], 1'b0, 32'h0);
      `CHK(rd[7:0], rows[i][3])
      `CHK(rows[i][0][2] ? GPIO2_OE_O : GPIO1_OE_O, ~rows[i][1])
    end
    low2 <= 8'h00;
    // every base chosen keeps the ports clear of the config and status words
    // base moves to I/O 004h: port 1 lands on byte 10h, the old place goes dead
    xfer(32'h4_0000, 1'b1, 32'h01);
    xfer(32'h10, 1'b0, 32'h0);
    `CHK(rd, 32'hc3)
    xfer(32'h1e0, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    xfer(32'h4_0000, 1'b1, 32'hff);
    xfer(32'h4_0000, 1'b0, 32'h0);
    `CHK(rd, 32'hff)
    xfer(32'hff4, 1'b1, 32'h5a);
    repeat (4) @(posedge CLK_I);
    xfer(32'hff4, 1'b0, 32'h0);
    `CHK(rd, 32'h5a)
    xfer(32'hff0, 1'b0, 32'h0);
    `CHK(rd, 32'hc3)
    xfer(32'hff5, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    // mid-run reset with the strap low: base back to 78h, ports silent
    do_reset(1'b0);
    xfer(32'h4_0000, 1'b0, 32'h0);
    `CHK(rd, 32'h1e)
    xfer(32'h4_0004, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    xfer(32'h1e0, 1'b1, 32'h0);
    repeat (4) @(posedge CLK_I);
    `CHK(GPIO1_OE_O, 8'h00)
    xfer(32'h1e0, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    tally_and_finish;
  end
  // watchdog against a hung bus
  initial begin
    repeat (2000) @(posedge CLK_I);
    err_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
